// ==== bench/host_port_props.sv ====
`timescale 1ns/1ps

module host_port_props (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic cpu_rd_i, // Processor read strobe
  input wire logic [7:0] cpu_rdata_o, // Processor read data
  input wire logic cpu_irq_o, // Processor interrupt
  input wire logic host_read_strobe_n_i, // Host read pin
  input wire logic host_write_strobe_n_i, // Host write pin
  input wire logic host_data_bus_oe_o, // Data bus drive enable
  input wire logic host_interrupt_func_o, // Interrupt pin function
  input wire logic dma_request_func_o, // Request pin function
  input wire logic dma_ack_func_o, // Acknowledge pin function
  input wire logic terminal_count_func_o, // Count pin function
  input wire logic status_select_func_o, // Select pin function
  input wire logic ram_req_o, // RAM request
  input wire logic ram_we_o, // RAM write
  input wire logic [10:0] ram_addr_o, // RAM address
  input wire logic ram_gnt_i // RAM grant
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////
  // Age of the last host write rise, saturating
  logic wr_q;
  logic [3:0] wr_age;
  always_ff @(posedge clk_i) begin
    wr_q <= host_write_strobe_n_i;
    if (!rst_n_i || (host_write_strobe_n_i && !wr_q)) begin
      wr_age <= 4'h0;
    end else if (wr_age != 4'hF) begin
      wr_age <= wr_age + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_rd_quiet;
    host_read_strobe_n_i [*4];
  endsequence
  sequence s_rd_fall;
    s_rd_quiet ##1 !host_read_strobe_n_i;
  endsequence

  a_oe_sync_lag: assert property (
    s_rd_fall |-> !host_data_bus_oe_o [*3])
    else $error("data bus driven before strobe synchronised");
  a_oe_read_only: assert property (
    host_data_bus_oe_o |-> !$past(host_read_strobe_n_i, 3))
    else $error("data bus driven outside a read");
  a_oe_release: assert property (
    $rose(host_read_strobe_n_i) |-> ##[1:4] !host_data_bus_oe_o)
    else $error("data bus not released after read");
  a_rdata_idle: assert property (
    !$past(cpu_rd_i) |-> cpu_rdata_o == 8'h00)
    else $error("read data outside its cycle");
  a_ram_req_hold: assert property (
    ram_req_o && !ram_gnt_i |=>
      ram_req_o && $stable(ram_addr_o) && $stable(ram_we_o))
    else $error("RAM request dropped or changed before grant");
  a_ram_req_once: assert property (
    ram_req_o && ram_gnt_i |=> !ram_req_o)
    else $error("RAM request repeated after grant");
  a_write_launch: assert property (
    $rose(ram_req_o) && ram_we_o |-> wr_age inside {[4'h2:4'h6]})
    else $error("RAM write not launched by strobe rise");
  a_reset_pin_fn: assert property (
    $rose(rst_n_i) |-> !(dma_request_func_o || dma_ack_func_o ||
      terminal_count_func_o || status_select_func_o ||
      host_interrupt_func_o || cpu_irq_o))
    else $error("pin functions not cleared by reset");
endmodule

bind external_host_fifo_port host_port_props u_props (
  .clk_i, .rst_n_i, .cpu_rd_i, .cpu_rdata_o, .cpu_irq_o,
  .host_read_strobe_n_i, .host_write_strobe_n_i, .host_data_bus_oe_o,
  .host_interrupt_func_o, .dma_request_func_o, .dma_ack_func_o,
  .terminal_count_func_o, .status_select_func_o, .ram_req_o, .ram_we_o,
  .ram_addr_o, .ram_gnt_i
);

// ==== bench/ram_partner.sv ====
`timescale 1ns/1ps

module ram_partner (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic req_i, // Access request
  input wire logic we_i, // Write
  input wire logic [10:0] addr_i, // Address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic [1:0] wait_i, // Clocks lost to the USB side
  output logic [7:0] rdata_o, // Read data on grant
  output logic gnt_o // Grant
);
  logic [7:0] mem [0:2047];
  logic [1:0] cnt;
  logic [7:0] last;

  assign gnt_o = req_i && (cnt >= wait_i);
  // Not granted: inverse of last value, never a stale match
  assign rdata_o = gnt_o ? mem[addr_i] : ~last;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !req_i || gnt_o) begin
      cnt <= 2'h0;
    end else begin
      cnt <= cnt + 2'h1;
    end
    if (!rst_n_i) begin
      last <= 8'h00;
    end else if (gnt_o) begin
      last <= rdata_o;
    end
    if (gnt_o && we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`include "host_port_cfg.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  err_count++; $display("Error %s exp %h got %h", n, e, g); end end

module tb;
  logic clk_i, rst_n_i, cpu_wr_i, cpu_rd_i, cpu_irq_o, hoe, rq;
  logic [2:0] cpu_addr_i;
  logic [7:0] cpu_wdata_i, cpu_rdata_o, host_data_bus_i, host_data_bus_o;
  logic [7:0] ram_wdata_o, ram_rdata_i, q, s;
  logic [10:0] ram_addr_o;
  logic host_chip_select_n_i, host_channel_address_i, host_data_bus_oe_o;
  logic host_read_strobe_n_i, host_write_strobe_n_i, status_select_in_i;
  logic host_interrupt_out_o, host_interrupt_func_o, dma_request_out_o;
  logic dma_request_func_o, dma_ack_n_i, dma_ack_func_o;
  logic terminal_count_n_i, terminal_count_func_o, status_select_func_o;
  logic ram_req_o, ram_we_o, ram_gnt_i;
  logic [1:0] wait_c;
  int err_count, n_compared;

  external_host_fifo_port dut (
    .clk_i, .rst_n_i, .cpu_addr_i, .cpu_wdata_i, .cpu_wr_i, .cpu_rd_i,
    .cpu_rdata_o, .cpu_irq_o, .host_chip_select_n_i,
    .host_channel_address_i, .host_read_strobe_n_i,
    .host_write_strobe_n_i, .host_data_bus_i, .host_data_bus_o,
    .host_data_bus_oe_o, .host_interrupt_out_o, .host_interrupt_func_o,
    .dma_request_out_o, .dma_request_func_o, .dma_ack_n_i, .dma_ack_func_o,
    .terminal_count_n_i, .terminal_count_func_o, .status_select_in_i,
    .status_select_func_o, .ram_req_o, .ram_we_o, .ram_addr_o,
    .ram_wdata_o, .ram_rdata_i, .ram_gnt_i
  );
  ram_partner ram (
    .clk_i, .rst_n_i, .req_i(ram_req_o), .we_i(ram_we_o),
    .addr_i(ram_addr_o), .wdata_i(ram_wdata_o), .wait_i(wait_c),
    .rdata_o(ram_rdata_i), .gnt_o(ram_gnt_i)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    cpu_wr_i <= 1'b1;
    @(posedge clk_i);
    cpu_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] o);
    @(posedge clk_i);
    cpu_addr_i <= a;
    cpu_rd_i <= 1'b1;
    @(posedge clk_i);
    cpu_rd_i <= 1'b0;
    #1 o = cpu_rdata_o;
  endtask

  task automatic win(input logic [2:0] i, input logic [7:0] lo, hi);
    wr(`OFS_INDEX, {5'h00, i});
    wr(`OFS_WIN_LO, lo);
    wr(`OFS_WIN_HI, hi);
  endtask

  // wide spacing keeps the host under the channel rate
  task automatic host(input logic a0, dk, r, tc, input logic [7:0] d,
                      output logic [7:0] o);
    @(posedge clk_i);
    host_chip_select_n_i <= dk;
    dma_ack_n_i <= !dk;
    host_channel_address_i <= a0;
    host_data_bus_i <= d;
    terminal_count_n_i <= !tc;
    if (r) host_read_strobe_n_i <= 1'b0;
    else host_write_strobe_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1 o = host_data_bus_o;
    hoe = host_data_bus_oe_o;
    rq = dma_request_out_o;
    @(posedge clk_i);
    host_read_strobe_n_i <= 1'b1;
    host_write_strobe_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    host_chip_select_n_i <= 1'b1;
    dma_ack_n_i <= 1'b1;
    terminal_count_n_i <= 1'b1;
    host_data_bus_i <= ~d;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    $display("Error run_time exp done got hang");
    summarize();
  end

  initial begin
    {rst_n_i, cpu_wr_i, cpu_rd_i, cpu_addr_i, cpu_wdata_i} = '0;
    {host_chip_select_n_i, host_read_strobe_n_i} = 2'h3;
    {host_write_strobe_n_i, dma_ack_n_i, terminal_count_n_i} = 3'h7;
    {host_channel_address_i, status_select_in_i} = 2'h0;
    host_data_bus_i = 8'h00;
    wait_c = 2'h2;
    err_count = 0;
    n_compared = 0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(`OFS_SRC, q);
    `CHK("status", 8'h00, q & 8'h0D)
    q = {3'h0, dma_request_func_o, dma_ack_func_o, terminal_count_func_o,
         status_select_func_o, host_interrupt_func_o};
    `CHK("pin_fn", 8'h00, q)
    $display("test reset done");
    // CPU channel, host to processor
    wr(`OFS_SRC_EN, 8'h01);
    host(1'b1, 1'b0, 1'b0, 1'b0, 8'hA5, q);
    rd(`OFS_SRC, q);
    `CHK("rx_full", 1'b1, q[0])
    `CHK("cpu_irq", 1'b1, cpu_irq_o)
    wr(`OFS_INDEX, {5'h00, `IDX_BUF});
    rd(`OFS_WIN_LO, q);
    `CHK("rx_byte", 8'hA5, q)
    rd(`OFS_SRC, q);
    `CHK("rx_clear", 1'b0, q[0])
    `CHK("irq_clear", 1'b0, cpu_irq_o)
    // CPU channel, processor to host
    wr(`OFS_SRC_EN, 8'h03);
    wr(`OFS_WIN_LO, 8'h3C);
    host(1'b1, 1'b0, 1'b1, 1'b0, 8'h00, q);
    `CHK("tx_byte", 8'h3C, q)
    `CHK("oe_in_read", 1'b1, hoe)
    `CHK("oe_idle", 1'b0, host_data_bus_oe_o)
    $display("test cpu channel done");
    win(`IDX_CFG, 8'h14, 8'h00);
    `CHK("sel_fn", 1'b1, status_select_func_o)
    `CHK("int_fn", 1'b1, host_interrupt_func_o)
    `CHK("int_pin", 1'b1, host_interrupt_out_o)
    rd(`OFS_SRC, s);
    @(posedge clk_i);
    status_select_in_i <= 1'b1;
    host(1'b1, 1'b0, 1'b1, 1'b0, 8'h00, q);
    `CHK("status_val", 8'h02, s)
    `CHK("status_read", s, q)
    @(posedge clk_i);
    status_select_in_i <= 1'b0;
    $display("test status read done");
    // Memory channel writes, single mode, last byte by terminal count
    wr(`OFS_SRC_EN, 8'h00);
    win(`IDX_ADDR, 8'h10, 8'h00);
    win(`IDX_END, 8'h1F, 8'h00);
    win(`IDX_MODE, 8'h02, 8'h00);
    win(`IDX_CFG, 8'h01, 8'h12);
    wr(`OFS_SRC_EN, 8'h08);
    host(1'b0, 1'b0, 1'b0, 1'b0, 8'h11, q);
    `CHK("single_drop", 1'b0, rq)
    `CHK("single_req", 1'b1, dma_request_out_o)
    host(1'b0, 1'b0, 1'b0, 1'b0, 8'h22, q);
    wr(`OFS_INDEX, {5'h00, `IDX_ADDR});
    wr(`OFS_WIN_LO, 8'h00);
    rd(`OFS_WIN_LO, q);
    `CHK("addr_count", 8'h12, q)
    host(1'b0, 1'b0, 1'b0, 1'b1, 8'h33, q);
    rd(`OFS_SRC, q);
    `CHK("tc_end", 2'h3, q[3:2])
    `CHK("ram_0", 8'h11, ram.mem[16])
    `CHK("ram_1", 8'h22, ram.mem[17])
    `CHK("ram_2", 8'h33, ram.mem[18])
    $display("test memory write done");
    // Memory channel reads by acknowledge, burst mode
    wr(`OFS_SRC_EN, 8'h00);
    win(`IDX_ADDR, 8'h10, 8'h00);
    win(`IDX_END, 8'h12, 8'h00);
    win(`IDX_MODE, 8'h05, 8'h00);
    win(`IDX_CFG, 8'h00, 8'h16);
    wr(`OFS_SRC_EN, 8'h08);
    repeat (10) @(posedge clk_i);
    `CHK("ack_fn", 2'h3, {dma_ack_func_o, dma_request_func_o})
    `CHK("burst_req", 1'b1, dma_request_out_o)
    host(1'b0, 1'b1, 1'b1, 1'b0, 8'h00, q);
    `CHK("fifo_0", 8'h11, q)
    `CHK("burst_strobe", 1'b1, rq)
    `CHK("burst_hold", 1'b1, dma_request_out_o)
    host(1'b0, 1'b1, 1'b1, 1'b0, 8'h00, q);
    `CHK("fifo_1", 8'h22, q)
    host(1'b0, 1'b1, 1'b1, 1'b0, 8'h00, q);
    `CHK("fifo_2", 8'h33, q)
    rd(`OFS_SRC, q);
    `CHK("end_addr", 2'h3, q[3:2])
    `CHK("req_stop", 1'b0, dma_request_out_o)
    $display("test memory read done");
    summarize();
  end
endmodule

// ==== rtl/external_host_fifo_port.sv ====
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "host_port_cfg.svh"

module external_host_fifo_port (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Synchronous reset, active low
  // Processor register port
  input wire logic [2:0] cpu_addr_i, // Register offset
  input wire logic [7:0] cpu_wdata_i, // Write data
  input wire logic cpu_wr_i, // Write strobe
  input wire logic cpu_rd_i, // Read strobe
  output logic [7:0] cpu_rdata_o, // Read data, cycle after strobe
  output logic cpu_irq_o, // Interrupt to the processor
  // Host pins
  input wire logic host_chip_select_n_i, // Host select, low active
  input wire logic host_channel_address_i, // High CPU, low memory channel
  input wire logic host_read_strobe_n_i, // Read strobe, low active
  input wire logic host_write_strobe_n_i, // Write strobe, low active
  input wire logic [7:0] host_data_bus_i, // Data bus in
  output logic [7:0] host_data_bus_o, // Data bus out
  output logic host_data_bus_oe_o, // Data bus drive enable
  output logic host_interrupt_out_o, // Interrupt toward host
  output logic host_interrupt_func_o, // Interrupt pin in host function
  output logic dma_request_out_o, // DMA request
  output logic dma_request_func_o, // Request pin in DMA function
  input wire logic dma_ack_n_i, // DMA acknowledge, low active
  output logic dma_ack_func_o, // Acknowledge pin in DMA function
  input wire logic terminal_count_n_i, // Terminal count, low active
  output logic terminal_count_func_o, // Count pin in DMA function
  input wire logic status_select_in_i, // Status read select
  output logic status_select_func_o, // Select pin in port function off
  // Shared RAM
  output logic ram_req_o, // RAM access request
  output logic ram_we_o, // RAM write
  output logic [10:0] ram_addr_o, // RAM address
  output logic [7:0] ram_wdata_o, // RAM write data
  input wire logic [7:0] ram_rdata_i, // RAM read data
  input wire logic ram_gnt_i // Grant, USB side has priority
);

  host_port_pkg::port_state_t s_r;
  host_port_pkg::port_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edges

  logic [14:0] pins_raw;
  logic [14:0] pins_s;
  logic [1:0] strobe_rise;
  logic cs_n;
  logic a0;
  logic rd_n;
  logic wr_n;
  logic dma_ack_level_n;
  logic tc_n;
  logic a1;
  logic [7:0] din;

  assign pins_raw = {host_chip_select_n_i, host_channel_address_i,
                     host_read_strobe_n_i, host_write_strobe_n_i,
                     dma_ack_n_i, terminal_count_n_i, status_select_in_i,
                     host_data_bus_i};

  pin_sync #(
    .WIDTH(15)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(pins_raw),
    .rst_val_i({4'hf, 3'h6, 8'h00}),
    .sync_o(pins_s)
  );

  assign {cs_n, a0, rd_n, wr_n, dma_ack_level_n, tc_n, a1, din} = pins_s;

  rise_detect #(
    .WIDTH(2)
  ) u_rise (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .level_i({rd_n, wr_n}),
    .rise_o(strobe_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command decoder

  logic rx_en;
  logic tx_en;
  logic mc_en;
  logic dma_ack_level_fn;
  logic tc_fn;
  logic a1_fn;
  logic port_en;
  logic burst;
  logic [1:0] dir;
  logic mc_active;
  logic mem_rx_enable;
  logic mem_tx_enable;
  logic cpu_sel;
  logic mem_pin;
  logic cpu_chan_read;
  logic cpu_chan_write;
  logic mem_chan_read;
  logic mem_chan_write;
  logic mem_chan_terminal_count;
  logic buffer_write;
  logic status_select;
  logic data_output_enable;
  logic mem_tx_buffer_control;
  logic tx_buffer_ready;
  logic rx_buffer_ready;
  logic [7:0] src_val;
  logic at_end;

  assign rx_en = s_r.src_en[`BIT_RX_EN];
  assign tx_en = s_r.src_en[`BIT_TX_EN];
  assign mc_en = s_r.src_en[`BIT_MC_EN];
  // Each DMA pin picks its own function
  assign dma_ack_level_fn = s_r.cfg_hi[`BIT_DAK_FN];
  assign tc_fn = s_r.cfg_hi[`BIT_TC_FN];
  assign a1_fn = s_r.cfg_lo[`BIT_A1_FN];
  assign port_en = s_r.cfg_lo[`BIT_PORT_EN];
  assign burst = s_r.mode[`BIT_BURST];
  assign dir = s_r.mode[`POS_DIR +: 2];

  assign mc_active = mc_en && (s_r.mc_status != `MC_END);
  assign mem_rx_enable = mc_active && (dir == `DIR_FROM_HOST);
  assign mem_tx_enable = mc_active && (dir == `DIR_TO_HOST);

  // Channel address high selects CPU side
  assign cpu_sel = !cs_n && a0;
  // Channel address low selects RAM side
  // Acknowledge alone also selects RAM side
  // Select and acknowledge together pick RAM side at either address
  assign mem_pin = (!cs_n && !a0 && port_en) || (dma_ack_level_fn && !dma_ack_level_n);

  assign cpu_chan_read = cpu_sel && strobe_rise[1] && tx_en && !status_select;
  assign cpu_chan_write = cpu_sel && strobe_rise[0] && rx_en;
  // Memory channel needs config and enables
  assign mem_chan_read = mem_pin && strobe_rise[1] && mem_tx_enable;
  assign mem_chan_write = mem_pin && strobe_rise[0] && mem_rx_enable &&
                          !s_r.mrx_pending;
  assign mem_chan_terminal_count = mem_chan_write && tc_fn && !tc_n;
  assign buffer_write = (cpu_chan_write && !s_r.rx_full) || mem_chan_write;
  assign status_select = a1_fn && a1 && cpu_sel;
  assign data_output_enable = !rd_n && (cpu_sel || (mem_pin && mem_tx_enable));

  assign tx_buffer_ready = tx_en && !s_r.tx_empty;
  assign rx_buffer_ready = rx_en && !s_r.rx_full;
  assign mem_tx_buffer_control = (s_r.st == host_port_pkg::ST_RAM_RD);
  assign at_end = (s_r.addr == s_r.end_a);

  assign src_val = {4'h0, s_r.mc_status, s_r.tx_empty, s_r.rx_full};

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = `RST_BYTE;

    // Processor reads
    if (cpu_rd_i) begin
      case (cpu_addr_i)
        `OFS_SRC_EN: s_nxt.rdata = s_r.src_en;
        `OFS_SRC: s_nxt.rdata = src_val;
        `OFS_INDEX: s_nxt.rdata = {5'h00, s_r.index};
        `OFS_WIN_LO: begin
          case (s_r.index)
            `IDX_CFG: s_nxt.rdata = s_r.cfg_lo;
            `IDX_BUF: s_nxt.rdata = s_r.rx_buf;
            `IDX_MODE: s_nxt.rdata = s_r.mode;
            `IDX_ADDR: s_nxt.rdata = s_r.addr[7:0];
            `IDX_END: s_nxt.rdata = s_r.end_a[7:0];
            default: s_nxt.rdata = `RST_BYTE;
          endcase
          if (s_r.index == `IDX_BUF) begin
            s_nxt.rx_full = 1'b0;
          end
        end
        `OFS_WIN_HI: begin
          case (s_r.index)
            `IDX_CFG: s_nxt.rdata = s_r.cfg_hi;
            `IDX_ADDR: s_nxt.rdata = {5'h00, s_r.addr[10:8]};
            `IDX_END: s_nxt.rdata = {5'h00, s_r.end_a[10:8]};
            default: s_nxt.rdata = `RST_BYTE;
          endcase
        end
        default: s_nxt.rdata = `RST_BYTE;
      endcase
    end

    // Writable registers; source register ignores writes
    if (cpu_wr_i) begin
      case (cpu_addr_i)
        `OFS_SRC_EN: s_nxt.src_en = cpu_wdata_i;
        `OFS_INDEX: s_nxt.index = cpu_wdata_i[2:0];
        `OFS_WIN_LO: begin
          case (s_r.index)
            `IDX_CFG: s_nxt.cfg_lo = cpu_wdata_i;
            `IDX_BUF: begin
              // RAM prefetch owns the buffer while the channel runs toward the host
              if (!mem_tx_enable) begin
                s_nxt.tx_buf = cpu_wdata_i;
                s_nxt.tx_empty = 1'b0;
              end
            end
            `IDX_MODE: s_nxt.mode = cpu_wdata_i;
            `IDX_ADDR: if (!mc_en) s_nxt.addr[7:0] = cpu_wdata_i;
            // End address writable at any time, even while enabled
            `IDX_END: s_nxt.end_a[7:0] = cpu_wdata_i;
            default: s_nxt.index = s_r.index;
          endcase
        end
        `OFS_WIN_HI: begin
          case (s_r.index)
            `IDX_CFG: s_nxt.cfg_hi = cpu_wdata_i;
            `IDX_ADDR: if (!mc_en) s_nxt.addr[10:8] = cpu_wdata_i[2:0];
            `IDX_END: s_nxt.end_a[10:8] = cpu_wdata_i[2:0];
            default: s_nxt.index = s_r.index;
          endcase
        end
        default: s_nxt.index = s_r.index;
      endcase
    end

    // Host write sets full, winning over a same-cycle clear
    if (buffer_write) begin
      s_nxt.rx_buf = din;
    end
    if (cpu_chan_write) begin
      s_nxt.rx_full = 1'b1;
    end
    // Host took the byte; set beats a same-cycle processor refill
    if (cpu_chan_read) begin
      s_nxt.tx_empty = 1'b1;
    end

    // Memory channel status follows the enable
    if (!mc_en) begin
      s_nxt.mc_status = `MC_IDLE;
      s_nxt.mtx_loaded = 1'b0;
      s_nxt.mrx_pending = 1'b0;
      s_nxt.tc_pending = 1'b0;
    end else if (s_r.mc_status == `MC_IDLE) begin
      s_nxt.mc_status = `MC_RUN;
    end

    if (mem_chan_write) begin
      s_nxt.mrx_pending = 1'b1;
      s_nxt.tc_pending = mem_chan_terminal_count;
    end

    // Counter steps per completed host read
    if (mem_chan_read) begin
      s_nxt.mtx_loaded = 1'b0;
      if (at_end) begin
        s_nxt.mc_status = `MC_END;
      end else begin
        s_nxt.addr = s_r.addr + 11'h001;
      end
    end

    // RAM sequencer
    case (s_r.st)
      host_port_pkg::ST_IDLE: begin
        if (s_r.mrx_pending && mc_en) begin
          s_nxt.st = host_port_pkg::ST_RAM_WR;
        end else if (mem_tx_enable && !s_r.mtx_loaded && !mem_chan_read) begin
          s_nxt.st = host_port_pkg::ST_RAM_RD;
        end
      end
      host_port_pkg::ST_RAM_WR: begin
        // Hold until the USB side yields
        if (ram_gnt_i) begin
          s_nxt.mrx_pending = 1'b0;
          s_nxt.st = host_port_pkg::ST_IDLE;
          if (s_r.tc_pending || at_end) begin
            s_nxt.mc_status = `MC_END;
          end else begin
            s_nxt.addr = s_r.addr + 11'h001;
          end
        end
      end
      host_port_pkg::ST_RAM_RD: begin
        // Hold until the USB side yields
        if (ram_gnt_i) begin
          s_nxt.tx_buf = ram_rdata_i;
          s_nxt.mtx_loaded = 1'b1;
          s_nxt.st = host_port_pkg::ST_IDLE;
        end
      end
      default: s_nxt.st = host_port_pkg::ST_IDLE;
    endcase
    if (!mc_en) begin
      s_nxt.st = host_port_pkg::ST_IDLE;
    end

    s_nxt.dout = status_select ? src_val : s_r.tx_buf;
    s_nxt.doe = data_output_enable;

    // Single mode: one request per byte
    // Burst: hold while the window runs
    if (burst) begin
      s_nxt.mc_req = mc_active && (dir != 2'h0);
    end else if (mem_rx_enable) begin
      s_nxt.mc_req = !s_r.mrx_pending && !(mem_pin && !wr_n);
    end else begin
      s_nxt.mc_req = mem_tx_enable && s_r.mtx_loaded &&
                     !(mem_pin && !rd_n);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      // Enables off, pins back to port
      s_r <= '0;
      s_r.tx_empty <= 1'b1;
      s_r.st <= host_port_pkg::ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and selectors

  logic [2:0] int_sel;
  logic [1:0] drq_sel;

  assign int_sel = s_r.cfg_lo[`POS_INT_SEL +: 3];
  assign drq_sel = s_r.cfg_hi[`POS_DRQ_SEL +: 2];

  always_comb begin
    case (int_sel)
      3'h1: host_interrupt_out_o = tx_buffer_ready;
      3'h2: host_interrupt_out_o = rx_buffer_ready;
      3'h3: host_interrupt_out_o = s_r.mc_req;
      default: host_interrupt_out_o = 1'b0;
    endcase
  end

  // Request pin carries rx ready or memory request
  always_comb begin
    case (drq_sel)
      2'h1: dma_request_out_o = rx_buffer_ready;
      2'h2: dma_request_out_o = s_r.mc_req;
      default: dma_request_out_o = 1'b0;
    endcase
  end

  assign host_interrupt_func_o = (int_sel != 3'h0);
  assign dma_request_func_o = (drq_sel != 2'h0);
  assign dma_ack_func_o = dma_ack_level_fn;
  assign terminal_count_func_o = tc_fn;
  assign status_select_func_o = a1_fn;

  assign cpu_irq_o = (rx_en && s_r.rx_full) || (tx_en && s_r.tx_empty) ||
                     (s_r.mc_status == `MC_END);

  assign cpu_rdata_o = s_r.rdata;
  assign host_data_bus_o = s_r.dout;
  assign host_data_bus_oe_o = s_r.doe;

  assign ram_req_o = (s_r.st != host_port_pkg::ST_IDLE);
  assign ram_we_o = (s_r.st == host_port_pkg::ST_RAM_WR);
  assign ram_addr_o = s_r.addr;
  assign ram_wdata_o = s_r.rx_buf;

endmodule

// ==== rtl/host_port_cfg.svh ====
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

// Register offsets on the processor port
`define OFS_SRC_EN 3'h0
`define OFS_SRC 3'h1
`define OFS_INDEX 3'h3
`define OFS_WIN_LO 3'h4
`define OFS_WIN_HI 3'h5

// Window indices
`define IDX_CFG 3'h0
`define IDX_BUF 3'h1
`define IDX_MODE 3'h2
`define IDX_ADDR 3'h3
`define IDX_END 3'h4

// Source enable bits
`define BIT_RX_EN 0
`define BIT_TX_EN 1
`define BIT_MC_EN 3

// Configuration low / high fields
`define BIT_PORT_EN 0
`define POS_INT_SEL 1
`define BIT_A1_FN 4
`define POS_DRQ_SEL 0
`define BIT_DAK_FN 2
`define BIT_TC_FN 4

// Mode fields
`define POS_DIR 0
`define BIT_BURST 2

// Memory channel status codes
`define MC_IDLE 2'h0
`define MC_RUN 2'h1
`define MC_END 2'h3

// Direction codes
`define DIR_TO_HOST 2'h1
`define DIR_FROM_HOST 2'h2

// Reset values
`define RST_BYTE 8'h00

// Longest wait for the shared RAM behind the USB side, in clocks
`define RAM_WAIT_MAX 2

`endif

// ==== rtl/host_port_pkg.sv ====
package host_port_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAM_WR = 2'b01,
    ST_RAM_RD = 2'b10
  } mc_state_t;

  typedef struct packed {
    logic [7:0] src_en;
    logic [2:0] index;
    logic [7:0] cfg_lo;
    logic [7:0] cfg_hi;
    logic [7:0] mode;
    logic [10:0] addr;
    logic [10:0] end_a;
    logic [7:0] rx_buf;
    logic [7:0] tx_buf;
    logic rx_full;
    logic tx_empty;
    logic mtx_loaded;
    logic mrx_pending;
    logic tc_pending;
    logic [1:0] mc_status;
    mc_state_t st;
    logic [7:0] rdata;
    logic [7:0] dout;
    logic doe;
    logic mc_req;
  } port_state_t;

endpackage

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] pin_i, // Asynchronous pins
  input wire logic [WIDTH-1:0] rst_val_i, // Idle level during reset
  output logic [WIDTH-1:0] sync_o // Synchronised levels
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // Only the second stage is read outside
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_r <= rst_val_i;
      sync_r <= rst_val_i;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = rst_n_i ? sync_r : rst_val_i;

endmodule

// ==== rtl/rise_detect.sv ====
`timescale 1ns/1ps

module rise_detect #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] level_i, // Synchronised levels
  output logic [WIDTH-1:0] rise_o // One-cycle pulse on a rising level
);

  logic [WIDTH-1:0] prev_r;

  // Reset to ones so a high idle level gives no false edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_r <= '1;
    end else begin
      prev_r <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_r;

endmodule
